// >>> hw/adcpp_pkg.sv
// Contract
// RULE1: Primary result held until ready flag clears
// RULE2: Primary result read clears status bits 2..0
// RULE3: Auxiliary result held; read clears bits 2..1
// RULE4: Primary offset preset, overwritten by calibration
// RULE5: Auxiliary offset preset, overwritten by calibration
// RULE6: Gain coefficient per channel, calibration overwrites
// RULE7: Software writes coefficients only after idle 23us
// RULE8: Result count limit, default one, when enabled
// RULE9: Result counter wraps to zero at limit
// RULE10: Control or mode write clears result counter
// RULE11: Compare magnitude against threshold, mode dependent width
// RULE12: Hit counter increments, decrements or clears
// RULE13: Threshold flag set when hits reach limit
// RULE14: Accumulator cleared when disabled or reconfigured
// RULE15: Software polls ready before reading accumulator
// RULE16: Accumulator above threshold sets exceeded flag
// RULE17: Enabled accumulator adds every primary result
// RULE18: Two-bit comparator mode field selects behaviour
// RULE19: Counter disabled means interrupt every conversion
`default_nettype none
package adcpp_pkg;
    localparam logic [31:0] ADDR_PRIMARY_RESULT = 32'hffff051c;
    localparam logic [31:0] ADDR_AUXILIARY_RESULT = 32'hffff0520;
    localparam logic [31:0] ADDR_PRIMARY_OFFSET_COEF = 32'hffff0524;
    localparam logic [31:0] ADDR_AUXILIARY_OFFSET_COEF = 32'hffff0528;
    localparam logic [31:0] ADDR_PRIMARY_GAIN_COEF = 32'hffff052c;
    localparam logic [31:0] ADDR_AUXILIARY_GAIN_COEF = 32'hffff0530;
    localparam logic [31:0] ADDR_RESULT_COUNT_LIMIT = 32'hffff0534;
    localparam logic [31:0] ADDR_RESULT_COUNT_VALUE = 32'hffff0538;
    localparam logic [31:0] ADDR_MAGNITUDE_THRESHOLD = 32'hffff053c;
    localparam logic [31:0] ADDR_THRESHOLD_HIT_LIMIT = 32'hffff0540;
    localparam logic [31:0] ADDR_THRESHOLD_HIT_COUNT = 32'hffff0544;
    localparam logic [31:0] ADDR_RESULT_ACCUMULATOR = 32'hffff0548;
    localparam logic [31:0] ADDR_ACCUMULATOR_THRESHOLD = 32'hffff054c;
    localparam logic [15:0] RST_RESULT_COUNT_LIMIT = 16'h0001;
    localparam logic [7:0] RST_THRESHOLD_HIT_LIMIT = 8'h01;
    // Status bit positions
    localparam int STA_PRIMARY_READY = 0;
    localparam int STA_AUX_READY = 1;
    localparam int STA_THRESHOLD = 2;
    localparam int STA_ACC_EXCEEDED = 3;
    localparam int STA_W = 4;
    // Comparator mode field codes
    localparam logic [1:0] CMP_OFF = 2'h0;
    localparam logic [1:0] CMP_ANY = 2'h1;
    localparam logic [1:0] CMP_CLEAR = 2'h2;
    localparam logic [1:0] CMP_DECR = 2'h3;
    localparam int COEF_COUNT = 4;
    localparam int COEF_PRI_OFS = 0;
    localparam int COEF_AUX_OFS = 1;
    localparam int COEF_PRI_GAIN = 2;
    localparam int COEF_AUX_GAIN = 3;
endpackage : adcpp_pkg
`default_nettype wire

// >>> hw/adcpp_coef_mem.sv
`default_nettype none
// Four calibration coefficients; calibration load wins over software write
module adcpp_coef_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4,
    parameter logic [WIDTH-1:0] PRESET = 16'h0000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Software write
    input wire logic wr_en,
    input wire logic [1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    // Calibration load, one bit per entry
    input wire logic [DEPTH-1:0] cal_load,
    input wire logic [WIDTH-1:0] cal_data,
    // Read port
    input wire logic [1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_entry
            always_ff @(posedge clk) begin
                if (rst) begin
                    mem[g] <= PRESET;
                end else if (cal_load[g]) begin
                    mem[g] <= cal_data;
                end else if (wr_en && wr_idx == 2'(g)) begin
                    mem[g] <= wr_data;
                end
            end
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem[rd_idx];
        end
    end
endmodule : adcpp_coef_mem
`default_nettype wire

// >>> hw/adcpp_top.sv
`default_nettype none
module adcpp_top #(
    parameter logic [15:0] FACTORY_COEF = 16'h8000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Processor register port
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    output logic [31:0] bus_rdata,
    output logic bus_rvalid,
    // Converter side
    input wire logic pri_valid,
    input wire logic [23:0] pri_data,
    input wire logic aux_valid,
    input wire logic [23:0] aux_data,
    input wire logic [3:0] cal_load,
    input wire logic [15:0] cal_data,
    // Configuration from neighbouring registers
    input wire logic result_counter_enable,
    input wire logic [1:0] comparator_mode_field,
    input wire logic accumulator_enable,
    input wire logic twos_complement,
    input wire logic primary_control_write,
    input wire logic converter_mode_write,
    // Status
    output logic [3:0] converter_status,
    output logic conversion_irq
);
    import adcpp_pkg::*;

    logic [23:0] primary_result;
    logic [23:0] auxiliary_result;
    logic [15:0] result_count_limit;
    logic [15:0] result_count_value;
    logic [15:0] magnitude_threshold;
    logic [7:0] threshold_hit_limit;
    logic [7:0] threshold_hit_count;
    logic [31:0] result_accumulator;
    logic [31:0] accumulator_threshold;
    logic [15:0] coef_rdata;
    logic [31:0] rd_addr_q;

    // Address decode
    wire sel_pri = bus_addr == ADDR_PRIMARY_RESULT;
    wire sel_aux = bus_addr == ADDR_AUXILIARY_RESULT;
    wire sel_rcl = bus_addr == ADDR_RESULT_COUNT_LIMIT;
    wire sel_th = bus_addr == ADDR_MAGNITUDE_THRESHOLD;
    wire sel_thl = bus_addr == ADDR_THRESHOLD_HIT_LIMIT;
    wire sel_ath = bus_addr == ADDR_ACCUMULATOR_THRESHOLD;
    wire sel_pof = bus_addr == ADDR_PRIMARY_OFFSET_COEF;
    wire sel_aof = bus_addr == ADDR_AUXILIARY_OFFSET_COEF;
    wire sel_pgn = bus_addr == ADDR_PRIMARY_GAIN_COEF;
    wire sel_agn = bus_addr == ADDR_AUXILIARY_GAIN_COEF;
    wire sel_coef = sel_pof | sel_aof | sel_pgn | sel_agn;
    wire [1:0] coef_idx = sel_aof ? 2'(COEF_AUX_OFS) :
                          sel_pgn ? 2'(COEF_PRI_GAIN) :
                          sel_agn ? 2'(COEF_AUX_GAIN) : 2'(COEF_PRI_OFS);
    wire rd_pri = bus_rd && sel_pri;
    wire rd_aux = bus_rd && sel_aux;

    // Calibration coefficients; software must respect the idle wait
    adcpp_coef_mem #(
        .WIDTH(16),
        .DEPTH(COEF_COUNT),
        .PRESET(FACTORY_COEF)
    ) u_coef (
        .clk(clk),
        .rst(rst),
        .wr_en(bus_wr && sel_coef), // RULE7
        .wr_idx(coef_idx),
        .wr_data(bus_wdata[15:0]),
        .cal_load(cal_load), // RULE4 RULE5 RULE6
        .cal_data(cal_data),
        .rd_idx(coef_idx),
        .rd_data(coef_rdata)
    );

    // Result capture: a full holding register is never overwritten
    wire pri_take = pri_valid && !converter_status[STA_PRIMARY_READY]; // RULE1
    wire aux_take = aux_valid && !converter_status[STA_AUX_READY]; // RULE3
    wire reconfig = primary_control_write || converter_mode_write;

    // Magnitude of the incoming primary result
    wire pri_neg = twos_complement && pri_data[23];
    wire [23:0] pri_mag = pri_neg ? 24'(-pri_data) : pri_data;
    wire [15:0] th_used = twos_complement ?
                          {1'b0, magnitude_threshold[14:0]} :
                          magnitude_threshold; // RULE11
    wire mag_hit = pri_mag >= {8'h00, th_used}; // RULE11
    wire [31:0] pri_ext = twos_complement ?
                          {{8{pri_data[23]}}, pri_data} :
                          {8'h00, pri_data};

    // Next values of the counters
    wire count_wrap = result_count_value + 16'h0001 >= result_count_limit;
    wire [15:0] next_count = count_wrap ? 16'h0000 :
                             result_count_value + 16'h0001; // RULE9
    logic [7:0] next_hits;
    always_comb begin
        next_hits = threshold_hit_count;
        case (comparator_mode_field) // RULE18
            CMP_OFF: next_hits = threshold_hit_count;
            CMP_ANY: next_hits = mag_hit ? 8'h01 : 8'h00;
            CMP_CLEAR: next_hits = mag_hit ?
                (threshold_hit_count == 8'hff ? 8'hff :
                 threshold_hit_count + 8'h01) : 8'h00; // RULE12
            CMP_DECR: next_hits = mag_hit ?
                (threshold_hit_count == 8'hff ? 8'hff :
                 threshold_hit_count + 8'h01) :
                (threshold_hit_count == 8'h00 ? 8'h00 :
                 threshold_hit_count - 8'h01); // RULE12
            default: next_hits = threshold_hit_count;
        endcase
    end
    wire cmp_active = comparator_mode_field != CMP_OFF;
    wire th_event = cmp_active && (comparator_mode_field == CMP_ANY ?
                    mag_hit : next_hits >= threshold_hit_limit); // RULE13
    wire [31:0] next_acc = result_accumulator + pri_ext; // RULE17
    wire irq_event = result_counter_enable ? count_wrap : 1'b1; // RULE8 RULE19

    // Holding registers
    always_ff @(posedge clk) begin
        if (rst) begin
            primary_result <= 24'h000000;
            auxiliary_result <= 24'h000000;
        end else begin
            if (pri_take) primary_result <= pri_data; // RULE1
            if (aux_take) auxiliary_result <= aux_data; // RULE3
        end
    end

    // Software writable limits and thresholds
    always_ff @(posedge clk) begin
        if (rst) begin
            result_count_limit <= RST_RESULT_COUNT_LIMIT; // RULE8
            magnitude_threshold <= 16'h0000;
            threshold_hit_limit <= RST_THRESHOLD_HIT_LIMIT; // RULE13
            accumulator_threshold <= 32'h00000000;
        end else if (bus_wr) begin
            if (sel_rcl) result_count_limit <= bus_wdata[15:0];
            if (sel_th) magnitude_threshold <= bus_wdata[15:0];
            if (sel_thl) threshold_hit_limit <= bus_wdata[7:0];
            if (sel_ath) accumulator_threshold <= bus_wdata;
        end
    end

    // Result counter, hit counter and accumulator
    always_ff @(posedge clk) begin
        if (rst || reconfig) begin
            result_count_value <= 16'h0000; // RULE10
            threshold_hit_count <= 8'h00;
        end else if (pri_take) begin
            if (result_counter_enable) result_count_value <= next_count; // RULE9
            threshold_hit_count <= next_hits; // RULE12
        end
    end

    always_ff @(posedge clk) begin
        if (rst || reconfig || !accumulator_enable) begin
            result_accumulator <= 32'h00000000; // RULE14
        end else if (pri_take) begin
            result_accumulator <= next_acc; // RULE17
        end
    end

    // Status flags: a threshold event in the same cycle as a read clear wins; a result is not taken while its ready flag is set
    wire clr_pri = rd_pri;
    wire clr_aux = rd_pri || rd_aux;
    always_ff @(posedge clk) begin
        if (rst) begin
            converter_status <= '0;
        end else begin
            converter_status[STA_PRIMARY_READY] <= pri_take ||
                (converter_status[STA_PRIMARY_READY] && !clr_pri); // RULE2
            converter_status[STA_AUX_READY] <= aux_take ||
                (converter_status[STA_AUX_READY] && !clr_aux); // RULE3
            converter_status[STA_THRESHOLD] <= (pri_take && th_event) ||
                (converter_status[STA_THRESHOLD] && !clr_aux); // RULE2 RULE13
            converter_status[STA_ACC_EXCEEDED] <= accumulator_enable &&
                result_accumulator > accumulator_threshold; // RULE16
        end
    end

    // Thinned conversion pulse; masking lives in the interrupt controller
    always_ff @(posedge clk) begin
        if (rst) begin
            conversion_irq <= 1'b0;
        end else begin
            conversion_irq <= pri_take && irq_event; // RULE8 RULE19
        end
    end

    // Read path: valid after one cycle, data after two; coefficient memory registers itself
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_addr_q <= 32'h00000000;
            bus_rvalid <= 1'b0;
        end else begin
            rd_addr_q <= bus_addr;
            bus_rvalid <= bus_rd;
        end
    end

    logic [31:0] next_rdata;
    always_comb begin
        case (rd_addr_q)
            ADDR_PRIMARY_RESULT: next_rdata = {8'h00, primary_result};
            ADDR_AUXILIARY_RESULT: next_rdata = {8'h00, auxiliary_result};
            ADDR_PRIMARY_OFFSET_COEF,
            ADDR_AUXILIARY_OFFSET_COEF,
            ADDR_PRIMARY_GAIN_COEF,
            ADDR_AUXILIARY_GAIN_COEF: next_rdata = {16'h0000, coef_rdata};
            ADDR_RESULT_COUNT_LIMIT:
                next_rdata = {16'h0000, result_count_limit};
            ADDR_RESULT_COUNT_VALUE:
                next_rdata = {16'h0000, result_count_value};
            ADDR_MAGNITUDE_THRESHOLD:
                next_rdata = {16'h0000, magnitude_threshold};
            ADDR_THRESHOLD_HIT_LIMIT:
                next_rdata = {24'h000000, threshold_hit_limit};
            ADDR_THRESHOLD_HIT_COUNT:
                next_rdata = {24'h000000, threshold_hit_count};
            ADDR_RESULT_ACCUMULATOR: next_rdata = result_accumulator;
            ADDR_ACCUMULATOR_THRESHOLD: next_rdata = accumulator_threshold;
            default: next_rdata = 32'h00000000;
        endcase
    end
    // Snapshot registers sampled on the same edge that the read data leaves
    logic [31:0] snap;
    always_ff @(posedge clk) begin
        if (rst) begin
            snap <= 32'h00000000;
        end else begin
            snap <= next_rdata;
        end
    end
    assign bus_rdata = snap;
endmodule : adcpp_top
`default_nettype wire

// >>> tb/adcpp_asserts.sv
`default_nettype none
module adcpp_asserts
    import adcpp_pkg::*;
(
    // Clock, reset and bus
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_rd,
    input wire logic [31:0] bus_addr,
    input wire logic bus_rvalid,
    // Converter side and status
    input wire logic pri_valid,
    input wire logic aux_valid,
    input wire logic result_counter_enable,
    input wire logic [1:0] comparator_mode_field,
    input wire logic accumulator_enable,
    input wire logic [3:0] converter_status,
    input wire logic conversion_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    wire logic [3:0] st = converter_status;
    wire logic rd_pri = bus_rd && bus_addr == ADDR_PRIMARY_RESULT;
    wire logic rd_aux = bus_rd && bus_addr == ADDR_AUXILIARY_RESULT;
    // A new result in the same cycle could legally re-set a flag
    wire logic quiet = !pri_valid && !aux_valid;
    chk_ready_set: assert property (
        pri_valid && !st[0] |=> st[0]) else $error("ready not set");
    chk_ready_hold: assert property (
        st[0] && !rd_pri |=> st[0]) else $error("ready dropped early");
    chk_pri_clear: assert property (
        rd_pri && quiet |=> st[2:0] == 3'h0) else $error("flags kept");
    chk_aux_clear: assert property (
        rd_aux && quiet |=> st[2:1] == 2'h0 && st[0] == $past(st[0]))
        else $error("aux read cleared wrong flags");
    chk_irq_every: assert property (
        pri_valid && !st[0] && !result_counter_enable |=> conversion_irq)
        else $error("no interrupt for conversion");
    chk_cmp_off: assert property (
        comparator_mode_field == CMP_OFF && !st[2] |=> !st[2])
        else $error("threshold flag while comparator off");
    chk_acc_off: assert property (
        !accumulator_enable [*3] |-> !st[3])
        else $error("exceeded flag while accumulator off");
    chk_rst_quiet: assert property (
        $fell(rst) |-> st == 4'h0 && !conversion_irq && !bus_rvalid)
        else $error("outputs busy after reset");
    cov_pri_read: cover property (rd_pri && st[0]);
    cov_thresh: cover property (st[2]);
    cov_acc: cover property (st[3]);
endmodule : adcpp_asserts
bind adcpp_top adcpp_asserts u_chk (.clk, .rst, .bus_rd, .bus_addr,
    .bus_rvalid, .pri_valid, .aux_valid, .result_counter_enable,
    .comparator_mode_field, .accumulator_enable, .converter_status,
    .conversion_irq);
`default_nettype wire

// >>> tb/adcpp_conv_model.sv
`default_nettype none
module adcpp_conv_model (
    // Clock
    input wire logic clk,
    // Converter outputs
    output logic pri_valid,
    output logic [23:0] pri_data,
    output logic aux_valid,
    output logic [23:0] aux_data,
    output logic [3:0] cal_load,
    output logic [15:0] cal_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pri_valid = 1'b0;
        aux_valid = 1'b0;
        cal_load = 4'h0;
        pri_data = 24'h0;
        aux_data = 24'h0;
        cal_data = 16'h0;
    end
    // Channel 0 primary, 1 auxiliary, 2 to 5 calibration entries
    task automatic send(input int ch, input logic [23:0] d, input int lag);
        repeat (lag + 1) @(negedge clk);
        pri_valid = (ch == 0);
        aux_valid = (ch == 1);
        cal_load = (ch > 1) ? 4'h1 << (ch - 2) : 4'h0;
        pri_data = d;
        aux_data = d;
        cal_data = d[15:0];
        @(negedge clk);
        pri_valid = 1'b0;
        aux_valid = 1'b0;
        cal_load = 4'h0;
        // Junk outside a strobe so stale data is never trusted
        pri_data = ~d;
        aux_data = ~d;
        cal_data = ~d[15:0];
    endtask : send
endmodule : adcpp_conv_model
`default_nettype wire

// >>> tb/adc_result_postprocessor_tb_top.sv
`default_nettype none
module adc_result_postprocessor_tb_top
    import adcpp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] FC = 16'h3c5a; // Arbitrary factory preset
    logic clk = 1'b0, rst = 1'b1, bus_rd = 1'b0, bus_wr = 1'b0;
    logic rce = 1'b0, acc_en = 1'b0, tc = 1'b0, pcw = 1'b0, cmw = 1'b0;
    logic [1:0] cmf = CMP_OFF;
    logic [31:0] bus_addr = 32'h0, bus_wdata = 32'h0, bus_rdata, sum, ath, e;
    logic bus_rvalid, pri_valid, aux_valid, irq, rv_d = 1'b0;
    logic [23:0] pri_data, aux_data, d, a;
    logic [3:0] cal_load, status;
    logic [15:0] cal_data;
    logic [15:0] c [4];
    logic [7:0] hits, lim;
    logic [31:0] exp_q [$];
    int fails = 0, n_tests = 0, nirq = 0, n0;
    always #10 clk = ~clk;
    adcpp_top #(.FACTORY_COEF(FC)) u_adcpp_top (
        .clk, .rst, .bus_rd, .bus_wr, .bus_addr, .bus_wdata, .bus_rdata,
        .bus_rvalid, .pri_valid, .pri_data, .aux_valid, .aux_data,
        .cal_load, .cal_data, .result_counter_enable(rce),
        .comparator_mode_field(cmf), .accumulator_enable(acc_en),
        .twos_complement(tc), .primary_control_write(pcw),
        .converter_mode_write(cmw), .converter_status(status),
        .conversion_irq(irq));
    adcpp_conv_model u_adcpp_conv_model (.clk, .pri_valid, .pri_data,
        .aux_valid, .aux_data, .cal_load, .cal_data);
    task automatic cmp(input string what, input logic [31:0] ex, sn);
        n_tests++;
        if (sn !== ex) begin
            fails++;
            $display("Error %s expected %h seen %h", what, ex, sn);
        end
    endtask : cmp
    task automatic sta(input logic [3:0] ex);
        cmp("status", {28'h0, ex}, {28'h0, status});
    endtask : sta
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic reset();
        // Let a read still in flight deliver its data before reset
        @(negedge clk);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
    endtask : reset
    // Reads note their expected data; the monitor below checks it
    task automatic rw(input logic w, input logic [31:0] ad, v);
        @(negedge clk);
        bus_wr = w;
        bus_rd = !w;
        bus_addr = ad;
        bus_wdata = v;
        if (!w) exp_q.push_back(v);
        @(negedge clk);
        bus_wr = 1'b0;
        bus_rd = 1'b0;
    endtask : rw
    task automatic pulse(input logic sel);
        @(negedge clk);
        pcw = sel;
        cmw = !sel;
        @(negedge clk);
        pcw = 1'b0;
        cmw = 1'b0;
    endtask : pulse
    task automatic pc(input logic [23:0] v);
        u_adcpp_conv_model.send(0, v, 0);
        rw(1'b0, ADDR_PRIMARY_RESULT, 32'(v));
    endtask : pc
    task automatic tconv(input logic up, input logic neg);
        logic [23:0] m;
        m = (tc ? 24'h0 : 24'h8000) + (up ? 24'h100 : 24'h0);
        m = m + 24'($urandom % 256);
        if (neg) m = -m;
        u_adcpp_conv_model.send(0, m, 0);
        if (up) hits++;
        else hits = (cmf == CMP_DECR && hits != 8'h0) ? hits - 8'h1 : 8'h0;
        sta({1'b0, hits == lim, 2'h1});
        rw(1'b0, ADDR_PRIMARY_RESULT, 32'(m));
        rw(1'b0, ADDR_THRESHOLD_HIT_COUNT, 32'(hits));
    endtask : tconv
    // Read data lags the valid pulse by one cycle
    always @(negedge clk) begin
        if (rv_d) cmp("rdata", exp_q.pop_front(), bus_rdata);
        rv_d = (bus_rvalid === 1'b1);
    end
    always @(posedge clk) if (irq === 1'b1) nirq <= nirq + 1;
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        give_verdict();
    end
    initial begin
        void'($urandom(77826));
        reset();
        for (int i = 0; i < 14; i++) begin
            e = (i == 6 || i == 9) ? 32'h1 : 32'h0;
            if (i > 1 && i < 6) e = {16'h0, FC};
            rw(1'b0, ADDR_PRIMARY_RESULT + 32'(4 * i), e);
        end
        rw(1'b1, ADDR_RESULT_ACCUMULATOR, 32'h5a);
        rw(1'b0, ADDR_RESULT_ACCUMULATOR, 32'h0);
        d = 24'($urandom);
        a = 24'($urandom);
        u_adcpp_conv_model.send(0, d, 0);
        u_adcpp_conv_model.send(0, ~d, 2);
        u_adcpp_conv_model.send(1, a, 1);
        sta(4'h3);
        rw(1'b0, ADDR_AUXILIARY_RESULT, 32'(a));
        sta(4'h1);
        u_adcpp_conv_model.send(1, ~a, 0);
        rw(1'b0, ADDR_PRIMARY_RESULT, 32'(d));
        sta(4'h0);
        for (int k = 0; k < 4; k++) begin
            c[k] = 16'($urandom);
            u_adcpp_conv_model.send(k + 2, {8'h0, c[k]}, 0);
            e = ADDR_PRIMARY_OFFSET_COEF + 32'(4 * k);
            rw(1'b0, e, {16'h0, c[k]});
        end
        repeat (1150) @(negedge clk);
        for (int k = 0; k < 4; k++) begin
            e = ADDR_PRIMARY_OFFSET_COEF + 32'(4 * k);
            rw(1'b1, e, {16'h0, ~c[k]});
            rw(1'b0, e, {16'h0, ~c[k]});
        end
        rce = 1'b1;
        rw(1'b1, ADDR_RESULT_COUNT_LIMIT, 32'h3);
        pulse(1'b1);
        n0 = nirq;
        for (int i = 1; i < 7; i++) begin
            pc(24'($urandom));
            rw(1'b0, ADDR_RESULT_COUNT_VALUE, 32'(i % 3));
        end
        cmp("irq count", 32'(n0 + 2), 32'(nirq));
        pc(24'h1);
        pulse(1'b0);
        rw(1'b0, ADDR_RESULT_COUNT_VALUE, 32'h0);
        rce = 1'b0;
        n0 = nirq;
        pc(24'h2);
        pc(24'h3);
        cmp("irq count", 32'(n0 + 2), 32'(nirq));
        reset();
        rw(1'b1, ADDR_MAGNITUDE_THRESHOLD, 32'h8100);
        rw(1'b1, ADDR_THRESHOLD_HIT_LIMIT, 32'hff);
        hits = 8'h0;
        lim = 8'hff;
        cmf = CMP_CLEAR;
        repeat (8) tconv(1'($urandom), 1'b0);
        cmf = CMP_DECR;
        tc = 1'b1;
        repeat (8) tconv(1'($urandom), 1'($urandom));
        lim = hits + 8'h1;
        rw(1'b1, ADDR_THRESHOLD_HIT_LIMIT, 32'(lim));
        tconv(1'b1, 1'b0);
        for (int k = 0; k < 2; k++) begin
            cmf = k ? CMP_OFF : CMP_ANY;
            u_adcpp_conv_model.send(0, 24'h8200, 0);
            sta(k ? 4'h1 : 4'h5);
            rw(1'b0, ADDR_PRIMARY_RESULT, 32'h8200);
        end
        tc = 1'b0;
        ath = 32'h01000000;
        sum = 32'h0;
        rw(1'b1, ADDR_ACCUMULATOR_THRESHOLD, ath);
        acc_en = 1'b1;
        repeat (4) begin
            d = 24'($urandom);
            sum = sum + 32'(d);
            u_adcpp_conv_model.send(0, d, 1);
            rw(1'b0, ADDR_RESULT_ACCUMULATOR, sum);
            sta({sum > ath, 3'h1});
            rw(1'b0, ADDR_PRIMARY_RESULT, 32'(d));
        end
        pulse(1'b1);
        rw(1'b0, ADDR_RESULT_ACCUMULATOR, 32'h0);
        acc_en = 1'b0;
        rw(1'b0, ADDR_RESULT_ACCUMULATOR, 32'h0);
        sta(4'h0);
        repeat (4) @(negedge clk);
        cmp("pending reads", 32'h0, 32'(exp_q.size()));
        give_verdict();
    end
endmodule : adc_result_postprocessor_tb_top
`default_nettype wire
